// >>> rtl/calib_lane.sv
// one byte lane of the read-calibration pattern driver
`timescale 1ns/1ps
module calib_lane (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // controls
   input wire logic [7:0] pattern_i,
   input wire logic [7:0] invert_i,
   input wire logic active_i,
   // lane outputs
   output logic [7:0] dq_o,
   output logic mask_inversion_o
);
   typedef struct packed {
      logic [7:0] dq;
      logic mask_inversion_pin;
   } lane_state_type;
   lane_state_type state_reg, state_next;

   always_comb begin
      state_next = '0;
      if (active_i) begin
         // (RULE7) per-line invert bits
         // (RULE8) same mapping, upper lane
         state_next.dq = pattern_i ^ invert_i;
         // (RULE9) mask pin true pattern
         // (RULE10) upper mask pin true
         state_next.mask_inversion_pin = pattern_i[0];
      end
   end

   // registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign dq_o = state_reg.dq;
   assign mask_inversion_o = state_reg.mask_inversion_pin;
endmodule // calib_lane

// >>> rtl/mode_regs.sv
// mode-register slice: reference level, invert masks, refresh masks, osc count
//
// Behaviour
// (RULE1) six-bit reference code in bits 5..0
// (RULE2) bit 6 selects reference range
// (RULE3) read drives eight bits, rest zero
// (RULE4) code write goes to write set point
// (RULE5) two copies, access via write select
// (RULE6) operate only from operate-select copy
// (RULE7) low invert bits flip DQ0..DQ7 pattern
// (RULE8) high invert bits flip DQ8..DQ15
// (RULE9) low mask pin never inverted
// (RULE10) high mask pin never inverted
// (RULE11) no bus inversion during calibration
// (RULE12) bank mask bit disables bank refresh
// (RULE13) bank masks kept per channel
// (RULE14) segment mask bit disables segment refresh
// (RULE15) segment masks kept per channel
// (RULE16) count read as low and high byte
// (RULE17) oscillator start clears both count bytes
// (RULE18) controller may retune strobe phase
// (RULE19) write select bit 6, default zero
// (RULE20) operate select bit 7, default zero
// (RULE21) controller never writes reserved codes
`timescale 1ns/1ps
module mode_regs (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // serial command link from the controller
   input wire logic link_clk_i,
   input wire logic link_sel_i,
   input wire logic link_data_i,
   input wire logic link_chan_i,
   // oscillator events
   input wire logic osc_start_i,
   input wire logic osc_tick_i,
   // calibration
   input wire logic calib_active_i,
   input wire logic [7:0] calib_pattern_i,
   input wire logic bus_inversion_en_i,
   // read data
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_n_o,
   output logic [1:0] mask_inversion_pin_o,
   // operating values
   output logic [5:0] dq_reference_code_o,
   output logic dq_reference_range_o,
   output logic [15:0] bank_refresh_disable_o,
   output logic [15:0] segment_refresh_disable_o,
   output logic [15:0] osc_count_o
);
   typedef struct packed {
      mode_regs_pkg::link_state_type st;
      logic [3:0] bit_cnt;
      logic [14:0] shift;
      logic chan;
      logic sp_write;
      logic sp_operate;
      logic [6:0] ref_sp0;
      logic [6:0] ref_sp1;
      logic [7:0] low_inv;
      logic [7:0] high_inv;
      logic [15:0] bank_mask;
      logic [15:0] seg_mask;
      logic [15:0] osc_cnt;
      logic [7:0] rd_shift;
      logic rd_drive;
      logic [5:0] op_code;
      logic op_range;
   } regs_state_type;
   regs_state_type state_reg, state_next;

   logic clk_level, clk_rise, sel_level, sel_rise, data_level, start_rise, tick_rise;
   logic [7:0] low_dq, high_dq;
   logic low_dmi, high_dmi;
   logic chan_level;

   // channel-indexed eight-bit slot of a sixteen-bit mask
   function automatic logic [15:0] put_chan(input logic [15:0] m, input logic c,
                                            input logic [7:0] v);
      logic [15:0] r;
      r = m;
      if (c) begin
         r[15:8] = v;
      end else begin
         r[7:0] = v;
      end
      return r;
   endfunction

   // the link clock is just a sampled pin here
   pin_sync u_clk (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(link_clk_i),
      .level_o(clk_level),
      .rise_o(clk_rise)
   );
   pin_sync u_sel (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(link_sel_i),
      .level_o(sel_level),
      .rise_o(sel_rise)
   );
   // same latency as select, so channel is settled at the frame start
   pin_sync u_chan (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(link_chan_i),
      .level_o(chan_level),
      .rise_o()
   );
   pin_sync u_dat (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(link_data_i),
      .level_o(data_level),
      .rise_o()
   );
   pin_sync u_start (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(osc_start_i),
      .level_o(),
      .rise_o(start_rise)
   );
   pin_sync u_tick (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pin_i(osc_tick_i),
      .level_o(),
      .rise_o(tick_rise)
   );

   // (RULE11) inversion enable deliberately ignored
   calib_lane u_low (.core_clk_i(core_clk_i), .rst_i(rst_i),
                     .pattern_i(calib_pattern_i), .invert_i(state_reg.low_inv),
                     .active_i(calib_active_i), .dq_o(low_dq), .mask_inversion_o(low_dmi));
   calib_lane u_high (.core_clk_i(core_clk_i), .rst_i(rst_i),
                      .pattern_i(calib_pattern_i), .invert_i(state_reg.high_inv),
                      .active_i(calib_active_i), .dq_o(high_dq), .mask_inversion_o(high_dmi));

   logic unused_dbi;
   assign unused_dbi = bus_inversion_en_i;

   always_comb begin
      logic [5:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic is_read;
      logic [6:0] sel_ref;
      addr = state_reg.shift[13:8];
      wdata = state_reg.shift[7:0];
      is_read = state_reg.shift[14];
      rdata = 8'h00;
      state_next = state_reg;

      // (RULE5) reads reach the write-selected copy
      sel_ref = state_reg.sp_write ? state_reg.ref_sp1 : state_reg.ref_sp0;
      // (RULE3) unused and reserved bits read zero
      case (addr)
         mode_regs_pkg::ADDR_SETPOINT_CTRL:
            rdata = {state_reg.sp_operate, state_reg.sp_write, 6'h00};
         mode_regs_pkg::ADDR_DQ_REF: rdata = {1'b0, sel_ref};
         // (RULE16) count split into two read-only bytes
         mode_regs_pkg::ADDR_OSC_LOW: rdata = state_reg.osc_cnt[7:0];
         mode_regs_pkg::ADDR_OSC_HIGH: rdata = state_reg.osc_cnt[15:8];
         default: rdata = 8'h00;
      endcase

      // oscillator counter; start wins over a tick
      if (start_rise) begin
         // (RULE17) start command clears both bytes
         state_next.osc_cnt = '0;
      end else if (tick_rise && state_reg.osc_cnt != 16'hFFFF) begin
         state_next.osc_cnt = state_reg.osc_cnt + 16'h0001;
      end

      case (state_reg.st)
         mode_regs_pkg::ST_IDLE: begin
            // read data keeps standing here until the next frame starts
            if (sel_rise) begin
               state_next.st = mode_regs_pkg::ST_SHIFT;
               state_next.bit_cnt = '0;
               state_next.chan = chan_level;
            end
         end
         mode_regs_pkg::ST_SHIFT: begin
            if (!sel_level) begin
               // frame aborted early: drop it
               state_next.st = mode_regs_pkg::ST_IDLE;
            end else if (clk_rise) begin
               state_next.shift = {state_reg.shift[13:0], data_level};
               state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
               if (state_reg.bit_cnt == mode_regs_pkg::FRAME_LAST) begin
                  state_next.st = mode_regs_pkg::ST_READ;
               end
            end
         end
         mode_regs_pkg::ST_READ: begin
            if (is_read) begin
               state_next.rd_shift = rdata;
               state_next.rd_drive = 1'b1;
            end else begin
               case (addr)
                  mode_regs_pkg::ADDR_SETPOINT_CTRL: begin
                     // (RULE19) write select bit
                     state_next.sp_write = wdata[mode_regs_pkg::SP_WRITE_BIT];
                     // (RULE20) operate select bit
                     state_next.sp_operate = wdata[mode_regs_pkg::SP_OPERATE_BIT];
                  end
                  mode_regs_pkg::ADDR_DQ_REF: begin
                     // (RULE1) six-bit code, stored as sent
                     // (RULE4) code lands in write-selected copy
                     // (RULE2) range bit stored with code
                     if (state_reg.sp_write) begin
                        state_next.ref_sp1 = wdata[mode_regs_pkg::REF_RANGE_BIT:0];
                     end else begin
                        state_next.ref_sp0 = wdata[mode_regs_pkg::REF_RANGE_BIT:0];
                     end
                  end
                  mode_regs_pkg::ADDR_LOW_INVERT: state_next.low_inv = wdata;
                  mode_regs_pkg::ADDR_HIGH_INVERT: state_next.high_inv = wdata;
                  // (RULE12) mask bit set disables bank
                  // (RULE13) separate slot per channel
                  mode_regs_pkg::ADDR_BANK_MASK:
                     state_next.bank_mask = put_chan(state_reg.bank_mask, state_reg.chan, wdata);
                  // (RULE14) mask bit set disables segment
                  // (RULE15) separate slot per channel
                  mode_regs_pkg::ADDR_SEG_MASK:
                     state_next.seg_mask = put_chan(state_reg.seg_mask, state_reg.chan, wdata);
                  default: ;
               endcase
            end
            state_next.st = mode_regs_pkg::ST_IDLE;
         end
         default: state_next.st = mode_regs_pkg::ST_IDLE;
      endcase

      // a new frame ends the read drive
      if (state_reg.rd_drive && sel_rise) begin
         state_next.rd_drive = 1'b0;
      end

      // (RULE6) operating values from operate-select copy
      state_next.op_code = state_reg.sp_operate ? state_reg.ref_sp1[mode_regs_pkg::REF_CODE_MSB:0]
                                                : state_reg.ref_sp0[mode_regs_pkg::REF_CODE_MSB:0];
      state_next.op_range = state_reg.sp_operate ?
                            state_reg.ref_sp1[mode_regs_pkg::REF_RANGE_BIT] :
                            state_reg.ref_sp0[mode_regs_pkg::REF_RANGE_BIT];
   end

   // registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.ref_sp0 <= mode_regs_pkg::DQ_REF_RESET;
         state_reg.ref_sp1 <= mode_regs_pkg::DQ_REF_RESET;
         state_reg.op_code <= mode_regs_pkg::DQ_REF_RESET[mode_regs_pkg::REF_CODE_MSB:0];
         state_reg.op_range <= mode_regs_pkg::DQ_REF_RESET[mode_regs_pkg::REF_RANGE_BIT];
      end else begin
         state_reg <= state_next;
      end
   end

   // output stage, all from flops
   typedef struct packed {
      logic [15:0] dq;
      logic [15:0] oe_n;
      logic [1:0] mask_inversion_pin;
   } out_state_type;
   out_state_type out_reg, out_next;

   always_comb begin
      out_next = '0;
      out_next.oe_n = 16'hFFFF;
      if (calib_active_i) begin
         out_next.dq = {high_dq, low_dq};
         out_next.mask_inversion_pin = {high_dmi, low_dmi};
         out_next.oe_n = 16'h0000;
      end else if (state_reg.rd_drive) begin
         out_next.dq = {8'h00, state_reg.rd_shift};
         out_next.oe_n = 16'h0000;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_reg <= '0;
         out_reg.oe_n <= 16'hFFFF;
      end else begin
         out_reg <= out_next;
      end
   end

   assign dq_o = out_reg.dq;
   assign dq_oe_n_o = out_reg.oe_n;
   assign mask_inversion_pin_o = out_reg.mask_inversion_pin;
   assign dq_reference_code_o = state_reg.op_code;
   assign dq_reference_range_o = state_reg.op_range;
   assign bank_refresh_disable_o = state_reg.bank_mask;
   assign segment_refresh_disable_o = state_reg.seg_mask;
   assign osc_count_o = state_reg.osc_cnt;
endmodule // mode_regs

// >>> rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // pin side
   input wire logic pin_i,
   // core side
   output logic level_o,
   output logic rise_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } sync_state_type;
   sync_state_type state_reg, state_next;

   // accept a change only once stages two and three agree
   always_comb begin
      state_next = state_reg;
      state_next.s1 = pin_i;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      state_next.rise = 1'b0;
      if (state_reg.s2 == state_reg.s3) begin
         state_next.level = state_reg.s3;
         state_next.rise = state_reg.s3 & ~state_reg.level;
      end
   end

   // registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level_o = state_reg.level;
   assign rise_o = state_reg.rise;
endmodule // pin_sync

// >>> shared/mode_regs_pkg.sv
// constants and types for the mode-register slice
package mode_regs_pkg;
   // register addresses on the command/address path
   localparam logic [5:0] ADDR_SETPOINT_CTRL = 6'h0D;
   localparam logic [5:0] ADDR_DQ_REF = 6'h0E;
   localparam logic [5:0] ADDR_LOW_INVERT = 6'h0F;
   localparam logic [5:0] ADDR_BANK_MASK = 6'h10;
   localparam logic [5:0] ADDR_SEG_MASK = 6'h11;
   localparam logic [5:0] ADDR_OSC_LOW = 6'h12;
   localparam logic [5:0] ADDR_OSC_HIGH = 6'h13;
   localparam logic [5:0] ADDR_HIGH_INVERT = 6'h14;
   localparam logic [5:0] ADDR_RESERVED_A = 6'h15;
   // field positions
   localparam int REF_CODE_MSB = 5;
   localparam int REF_RANGE_BIT = 6;
   localparam int SP_WRITE_BIT = 6;
   localparam int SP_OPERATE_BIT = 7;
   // reset values and top reference code
   localparam logic [6:0] DQ_REF_RESET = 7'h4D;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [5:0] REF_CODE_MAX = 6'h32;
   // frame layout: 1 command bit, 6 address bits, 8 data bits
   localparam int FRAME_BITS = 15;
   localparam logic [3:0] FRAME_LAST = 4'hE;
   localparam logic [3:0] READ_LAST = 4'h7;
   // widths
   localparam int OSC_WIDTH = 16;
   localparam int NUM_CHANNELS = 2;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_READ} link_state_type;
endpackage

// >>> testbench/ctrl_model.sv
// controller model: serial mode-register frames and count readout
`timescale 1ns/1ps
module ctrl_model (
   // clock and read return
   input wire logic core_clk_i,
   input wire logic [15:0] dq_i,
   input wire logic [15:0] dq_oe_n_i,
   // link and oscillator pins
   output logic link_clk_o,
   output logic link_sel_o,
   output logic link_data_o,
   output logic link_chan_o,
   output logic osc_start_o
);
   logic [14:0] word;
   initial begin
      link_clk_o = 1'b0;
      link_sel_o = 1'b0;
      link_data_o = 1'b0;
      link_chan_o = 1'b0;
      osc_start_o = 1'b0;
   end
   // half a 160 ns link period
   task automatic half();
      repeat (4) @(posedge core_clk_i);
   endtask
   // frame of n bits, msb first; clock rests low outside frames
   task automatic frame(input logic rd, input logic [5:0] a, input logic [7:0] d,
      input logic ch, input int n, output logic [7:0] q, output bit ok);
      ok = 1'b0;
      word = {rd, a, d};
      link_chan_o <= ch;
      link_sel_o <= 1'b1;
      for (int i = 14; i > 14 - n; i--) begin
         link_data_o <= word[i];
         half();
         link_clk_o <= 1'b1;
         half();
         link_clk_o <= 1'b0;
      end
      // bounded wait for the answer, or settle time for a write
      for (int w = 0; w < 24 && !ok; w++) begin
         @(posedge core_clk_i);
         ok = rd ? (dq_oe_n_i[0] === 1'b0) : (w == 7);
      end
      q = dq_i[7:0];
      link_sel_o <= 1'b0;
      // released data line must not keep its last level
      link_data_o <= ~link_data_o;
      half();
   endtask
   task automatic read_count(output logic [15:0] c, output bit ok);
      logic [7:0] lo;
      logic [7:0] hi;
      bit k;
      frame(1'b1, mode_regs_pkg::ADDR_OSC_LOW, 8'h00, 1'b0, 15, lo, k);
      frame(1'b1, mode_regs_pkg::ADDR_OSC_HIGH, 8'h00, 1'b0, 15, hi, ok);
      ok = ok && k;
      c = {hi, lo};
   endtask
   task automatic start_osc();
      osc_start_o <= 1'b1;
      half();
      osc_start_o <= 1'b0;
      half();
   endtask
endmodule // ctrl_model

// >>> testbench/mode_regs_chk.sv
// port checker for the mode-register slice
`timescale 1ns/1ps
module mode_regs_chk (
   // clock, reset and watched inputs
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic link_sel_i,
   input wire logic osc_start_i,
   input wire logic calib_active_i,
   input wire logic [7:0] calib_pattern_i,
   // watched outputs
   input wire logic [15:0] dq_o,
   input wire logic [15:0] dq_oe_n_o,
   input wire logic [1:0] mask_inversion_pin_o,
   input wire logic [5:0] dq_reference_code_o,
   input wire logic dq_reference_range_o,
   input wire logic [15:0] bank_refresh_disable_o,
   input wire logic [15:0] segment_refresh_disable_o,
   input wire logic [15:0] osc_count_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   logic [3:0] gap_reg;
   // cycles since select was high; settings move only near frames
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_reg <= 4'hF;
      end else if (link_sel_i) begin
         gap_reg <= 4'h0;
      end else if (gap_reg != 4'hF) begin
         gap_reg <= gap_reg + 4'h1;
      end
   end
   sequence cal_steady;
      calib_active_i && $past(calib_active_i) && $past(calib_active_i, 2)
         && $stable(calib_pattern_i) && $past(calib_pattern_i) == $past(calib_pattern_i, 2);
   endsequence
   sequence cal_quiet;
      !calib_active_i && !$past(calib_active_i) && !$past(calib_active_i, 2);
   endsequence
   a_reset_defaults: assert property (
      $fell(rst_i) |-> {dq_reference_range_o, dq_reference_code_o} == 7'h4D
         && bank_refresh_disable_o == 16'h0000 && osc_count_o == 16'h0000)
      else $error("not at reset values");
   a_count_clear: assert property (
      $rose(osc_start_i) |-> ##[1:8] osc_count_o == 16'h0000)
      else $error("count not cleared");
   a_count_step: assert property (
      $changed(osc_count_o) |-> osc_count_o == $past(osc_count_o) + 16'h0001
         || osc_count_o == 16'h0000)
      else $error("count jumped");
   a_mask_by_frame: assert property (
      $changed({bank_refresh_disable_o, segment_refresh_disable_o}) |-> gap_reg < 4'h8)
      else $error("mask moved outside frame");
   a_ref_by_frame: assert property (
      $changed({dq_reference_range_o, dq_reference_code_o}) |-> gap_reg < 4'h8)
      else $error("reference moved outside frame");
   a_mask_pin_true: assert property (
      cal_steady |-> mask_inversion_pin_o == {2{calib_pattern_i[0]}})
      else $error("mask pin not true pattern");
   a_dbi_no_effect: assert property (
      cal_steady ##1 (calib_active_i && $stable(calib_pattern_i)) |-> $stable(dq_o))
      else $error("pattern output moved");
   a_read_stands: assert property (
      cal_quiet ##0 (!dq_oe_n_o[0] && !link_sel_i) |=> $stable(dq_o[7:0]))
      else $error("read data dropped");
   a_upper_zero: assert property (
      cal_quiet ##0 !dq_oe_n_o[0] |-> dq_o[15:8] == 8'h00)
      else $error("upper lines driven on read");
endmodule // mode_regs_chk
bind mode_regs mode_regs_chk i_mode_regs_chk (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .link_sel_i(link_sel_i),
   .osc_start_i(osc_start_i), .calib_active_i(calib_active_i),
   .calib_pattern_i(calib_pattern_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
   .mask_inversion_pin_o(mask_inversion_pin_o), .dq_reference_code_o(dq_reference_code_o),
   .dq_reference_range_o(dq_reference_range_o),
   .bank_refresh_disable_o(bank_refresh_disable_o),
   .segment_refresh_disable_o(segment_refresh_disable_o), .osc_count_o(osc_count_o)
);

// >>> testbench/mode_regs_tb_top.sv
// testbench for the mode-register slice through the controller model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("Error %s exp %h got %h", nm, e, g); \
   end \
end
module mode_regs_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tick = 1'b0;
   logic cal_on = 1'b0;
   logic [7:0] cal_pat = 8'h00;
   logic dbi_en = 1'b0;
   logic l_clk, l_sel, l_data, l_chan, o_start, rng;
   logic [15:0] dq, oe_n, bank, seg, cnt, c;
   logic [1:0] mask_inversion_pin;
   logic [5:0] code;
   logic [7:0] q;
   bit ok;
   int err_total = 0;
   int checks_done = 0;
   // 50 MHz core clock
   always #10 clk = ~clk;
   mode_regs i_mode_regs (
      .core_clk_i(clk), .rst_i(rst), .link_clk_i(l_clk), .link_sel_i(l_sel),
      .link_data_i(l_data), .link_chan_i(l_chan), .osc_start_i(o_start), .osc_tick_i(tick),
      .calib_active_i(cal_on), .calib_pattern_i(cal_pat), .bus_inversion_en_i(dbi_en),
      .dq_o(dq), .dq_oe_n_o(oe_n), .mask_inversion_pin_o(mask_inversion_pin), .dq_reference_code_o(code),
      .dq_reference_range_o(rng), .bank_refresh_disable_o(bank),
      .segment_refresh_disable_o(seg), .osc_count_o(cnt)
   );
   ctrl_model i_ctrl_model (
      .core_clk_i(clk), .dq_i(dq), .dq_oe_n_i(oe_n), .link_clk_o(l_clk),
      .link_sel_o(l_sel), .link_data_o(l_data), .link_chan_o(l_chan), .osc_start_o(o_start)
   );
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic ch);
      i_ctrl_model.frame(1'b0, a, d, ch, 15, q, ok);
   endtask
   // a read with no answer ends the run
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      i_ctrl_model.frame(1'b1, a, 8'h00, 1'b0, 15, q, ok);
      if (!ok) begin
         err_total++;
         $display("Error read %h no answer", a);
         wrap_up();
      end
      `CHK($sformatf("read %h", a), e, q)
   endtask
   task automatic ref_chk(input logic [6:0] e);
      `CHK("reference", e, {rng, code})
   endtask
   // four cycles each level so the sampler catches every edge
   task automatic ticks(input int n);
      repeat (n) begin
         tick <= 1'b1;
         repeat (4) @(posedge clk);
         tick <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      ref_chk(7'h4D);
      rd(mode_regs_pkg::ADDR_DQ_REF, 8'h4D);
      rd(mode_regs_pkg::ADDR_SETPOINT_CTRL, 8'h00);
      // top legal code with the spare bit set
      wr(mode_regs_pkg::ADDR_DQ_REF, 8'hF2, 1'b0);
      rd(mode_regs_pkg::ADDR_DQ_REF, 8'h72);
      ref_chk(7'h72);
      // write copy 1 while copy 0 operates, then swap
      wr(mode_regs_pkg::ADDR_SETPOINT_CTRL, 8'h40, 1'b0);
      wr(mode_regs_pkg::ADDR_DQ_REF, 8'h05, 1'b0);
      rd(mode_regs_pkg::ADDR_DQ_REF, 8'h05);
      ref_chk(7'h72);
      wr(mode_regs_pkg::ADDR_SETPOINT_CTRL, 8'hC0, 1'b0);
      ref_chk(7'h05);
      wr(mode_regs_pkg::ADDR_SETPOINT_CTRL, 8'h80, 1'b0);
      rd(mode_regs_pkg::ADDR_DQ_REF, 8'h72);
      wr(mode_regs_pkg::ADDR_DQ_REF, 8'h11, 1'b0);
      ref_chk(7'h05);
      wr(mode_regs_pkg::ADDR_SETPOINT_CTRL, 8'h00, 1'b0);
      ref_chk(7'h11);
      // per-channel masks, then a cut frame that must be dropped
      wr(mode_regs_pkg::ADDR_BANK_MASK, 8'hA5, 1'b0);
      wr(mode_regs_pkg::ADDR_BANK_MASK, 8'h3C, 1'b1);
      wr(mode_regs_pkg::ADDR_SEG_MASK, 8'h81, 1'b0);
      wr(mode_regs_pkg::ADDR_SEG_MASK, 8'h7E, 1'b1);
      i_ctrl_model.frame(1'b0, mode_regs_pkg::ADDR_BANK_MASK, 8'hFF, 1'b0, 10, q, ok);
      `CHK("bank mask", 16'h3CA5, bank)
      `CHK("segment mask", 16'h7E81, seg)
      rd(mode_regs_pkg::ADDR_BANK_MASK, 8'h00);
      rd(mode_regs_pkg::ADDR_RESERVED_A, 8'h00);
      // calibration with inversion masks, bus inversion toggled
      wr(mode_regs_pkg::ADDR_LOW_INVERT, 8'h15, 1'b0);
      wr(mode_regs_pkg::ADDR_HIGH_INVERT, 8'hC3, 1'b0);
      cal_on <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("cal dq", 16'hC315, dq)
      `CHK("cal pin", 2'b00, mask_inversion_pin)
      `CHK("cal oe", 16'h0000, oe_n)
      cal_pat <= 8'hFF;
      dbi_en <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("cal dq", 16'h3CEA, dq)
      `CHK("cal pin", 2'b11, mask_inversion_pin)
      cal_on <= 1'b0;
      // count, ignored write, then restart
      ticks(260);
      repeat (8) @(posedge clk);
      `CHK("count", 16'h0104, cnt)
      `CHK("idle oe", 16'hFFFF, oe_n)
      wr(mode_regs_pkg::ADDR_OSC_LOW, 8'hFF, 1'b0);
      i_ctrl_model.read_count(c, ok);
      `CHK("count answer", 1'b1, ok)
      `CHK("count read", 16'h0104, c)
      i_ctrl_model.start_osc();
      i_ctrl_model.read_count(c, ok);
      `CHK("count answer", 1'b1, ok)
      `CHK("count read", 16'h0000, c)
      // second reset in mid-run
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      ref_chk(7'h4D);
      `CHK("segment mask", 16'h0000, seg)
      wrap_up();
   end
endmodule // mode_regs_tb_top
